// File: common/cell_admission_pkg.sv
package cell_admission_pkg;
  // ********************************************************
  // register byte offsets
  // ********************************************************
  localparam logic [7:0] OFS_THR_CLP1    = 8'h00;
  localparam logic [7:0] OFS_THR_ALL     = 8'h04;
  localparam logic [7:0] OFS_THR_EPD     = 8'h08;
  localparam logic [7:0] OFS_THR_MARK    = 8'h0C;
  localparam logic [7:0] OFS_THR_ALARM   = 8'h10;
  localparam logic [7:0] OFS_CONN_SEL    = 8'h14;
  localparam logic [7:0] OFS_CONN_CFG    = 8'h18;
  localparam logic [7:0] OFS_STATUS      = 8'h1C;
  localparam logic [7:0] OFS_DISCARD_CNT = 8'h20;
  // ********************************************************
  // field positions
  // ********************************************************
  localparam int CFG_POLICE_BIT   = 0;
  localparam int CFG_CLASS_LSB    = 1;
  localparam int CLASS_W          = 2;
  localparam int STAT_ALARM_BIT   = 16;
  localparam int STAT_READY_BIT   = 17;
  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [15:0] RST_THR_CLP1  = 16'h0030;
  localparam logic [15:0] RST_THR_ALL   = 16'h0040;
  localparam logic [15:0] RST_THR_EPD   = 16'h0038;
  localparam logic [15:0] RST_THR_MARK  = 16'h0020;
  localparam logic [15:0] RST_THR_ALARM = 16'h0030;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  // ********************************************************
  // manager states
  // ********************************************************
  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN  = 2'b10
  } mgr_state_t;
endpackage

// File: hdl/cell_admission_vc_queue_manager.sv
`timescale 1ns/1ps
// Functional notes
// - connection entry decides policing and conformance
// - unpoliced or conforming cells continue
// - policed nonconforming cells are dropped
// - congestion uses entry and buffer occupancy
// - separate low-priority and total discard thresholds
// - either threshold starts partial packet discard
// - early packet discard refuses whole packets
// - marking threshold sets congestion bit
// - alarm raised above backpressure threshold
// - passing cells are admitted to buffer
// - discarded cells are removed from stream
// - upstream dropped cells still update packet state
// - one linked-list FIFO per connection
// - free cells kept on a LIFO stack
// - elements carry next pointer and cell data
// - front and back pointers per connection
// - one global free stack top pointer
// - initialize, enqueue and dequeue operations
// - connection active while its queue nonempty
// - new session schedules connection in class
// - cells handled strictly in order
// - fixed stage order up to enqueue
module cell_admission_vc_queue_manager #(
  parameter int CONN_AW = 4,
  parameter int CELL_AW = 6,
  parameter int DATA_W  = 32
) (
  // clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                reset_in,
  // register bus
  input  wire logic [7:0]          avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic      [31:0]         avs_readdata_out,
  output logic                     avs_waitrequest_out,
  // arriving cells
  input  wire logic                cell_valid_in,
  output logic                     cell_ready_out,
  input  wire logic [CONN_AW-1:0]  cell_conn_in,
  input  wire logic [DATA_W-1:0]   cell_data_in,
  input  wire logic                cell_clp_in,
  input  wire logic                cell_eop_in,
  input  wire logic                cell_conform_in,
  input  wire logic                cell_dropped_in,
  // dequeue port
  input  wire logic                deq_req_in,
  input  wire logic [CONN_AW-1:0]  deq_conn_in,
  output logic                     deq_valid_out,
  output logic      [DATA_W-1:0]   deq_data_out,
  output logic                     deq_clp_out,
  output logic                     deq_mark_out,
  // scheduling and alarm
  output logic                     sched_valid_out,
  output logic      [CONN_AW-1:0]  sched_conn_out,
  output logic      [1:0]          sched_class_out,
  output logic                     fabric_backpressure_alarm_out
);
  localparam int CONNS = 1 << CONN_AW;
  localparam int CELLS = 1 << CELL_AW;
  localparam int OCC_W = CELL_AW + 1;

  // ********************************************************
  // storage
  // ********************************************************
  logic [DATA_W+1:0]   cell_mem [CELLS];
  logic [CELL_AW-1:0]  next_link [CELLS];
  logic [CELL_AW-1:0]  queue_front_pointer [CONNS];
  logic [CELL_AW-1:0]  queue_back_pointer [CONNS];
  logic [CONNS-1:0]    conn_active;
  logic [CONNS-1:0]    cfg_police;
  logic [1:0]          cfg_class [CONNS];
  logic [CONNS-1:0]    in_packet;
  logic [CONNS-1:0]    ppd_active;
  logic [CONNS-1:0]    epd_active;
  logic [CELL_AW-1:0]  free_stack_top_pointer;
  logic [CELL_AW-1:0]  init_idx;
  cell_admission_pkg::mgr_state_t state;
  logic [OCC_W-1:0]    occ_all;
  logic [OCC_W-1:0]    occ_clp1;
  logic [15:0]         thr_clp1;
  logic [15:0]         thr_all;
  logic [15:0]         thr_epd;
  logic [15:0]         thr_mark;
  logic [15:0]         thr_alarm;
  logic [CONN_AW-1:0]  conn_sel;
  logic [31:0]         discard_cnt;
  logic                bus_ack;

  function automatic logic over_thr(input logic [OCC_W-1:0] occ, input logic [15:0] thr);
    over_thr = {{(16-OCC_W){1'b0}}, occ} >= thr;
  endfunction

  // ********************************************************
  // admission decision
  // ********************************************************
  logic cell_take;
  logic deq_take;
  logic police_drop;
  logic free_empty;
  logic thr_cell;
  logic epd_hit;
  logic thr_drop;
  logic admit;
  logic mark_now;
  logic deq_clp_cell;

  assign free_empty     = occ_all == OCC_W'(CELLS);
  assign cell_ready_out = (state == cell_admission_pkg::ST_RUN) && !deq_req_in;
  assign cell_take      = cell_valid_in && cell_ready_out;
  assign deq_take       = (state == cell_admission_pkg::ST_RUN) && deq_req_in && conn_active[deq_conn_in];
  assign deq_clp_cell   = cell_mem[queue_front_pointer[deq_conn_in]][DATA_W+1];

  always_comb begin
    police_drop = cfg_police[cell_conn_in] && !cell_conform_in;
    thr_cell    = over_thr(occ_all, thr_all) || (cell_clp_in && over_thr(occ_clp1, thr_clp1));
    epd_hit     = !in_packet[cell_conn_in] && over_thr(occ_all, thr_epd);
    thr_drop    = ppd_active[cell_conn_in] || epd_active[cell_conn_in] || thr_cell || epd_hit || free_empty;
    admit       = cell_take && !cell_dropped_in && !police_drop && !thr_drop;
    mark_now    = over_thr(occ_all, thr_mark);
  end

  // ********************************************************
  // packet discard state per connection
  // ********************************************************
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      in_packet  <= '0;
      ppd_active <= '0;
      epd_active <= '0;
    end else if (cell_take && !(police_drop && !cell_dropped_in)) begin
      if (cell_eop_in) begin
        in_packet[cell_conn_in]  <= 1'b0;
        ppd_active[cell_conn_in] <= 1'b0;
        epd_active[cell_conn_in] <= 1'b0;
      end else begin
        in_packet[cell_conn_in] <= 1'b1;
        if (!cell_dropped_in && epd_hit) begin
          epd_active[cell_conn_in] <= 1'b1;
        end else if (!cell_dropped_in && (thr_cell || free_empty)) begin
          ppd_active[cell_conn_in] <= 1'b1;
        end
      end
    end
  end

  // ********************************************************
  // linked-list queues and free stack
  // ********************************************************
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state                  <= cell_admission_pkg::ST_INIT;
      init_idx               <= '0;
      free_stack_top_pointer <= '0;
      conn_active            <= '0;
    end else begin
      case (state)
        cell_admission_pkg::ST_INIT: begin
          next_link[init_idx] <= init_idx + CELL_AW'(1);
          init_idx            <= init_idx + CELL_AW'(1);
          if (init_idx == CELL_AW'(CELLS - 1)) begin
            state <= cell_admission_pkg::ST_RUN;
          end
        end
        default: begin
          if (admit) begin
            cell_mem[free_stack_top_pointer]  <= {cell_clp_in, mark_now, cell_data_in};
            free_stack_top_pointer            <= next_link[free_stack_top_pointer];
            queue_back_pointer[cell_conn_in]  <= free_stack_top_pointer;
            conn_active[cell_conn_in]         <= 1'b1;
            if (conn_active[cell_conn_in]) begin
              next_link[queue_back_pointer[cell_conn_in]] <= free_stack_top_pointer;
            end else begin
              queue_front_pointer[cell_conn_in] <= free_stack_top_pointer;
            end
          end else if (deq_take) begin
            queue_front_pointer[deq_conn_in] <= next_link[queue_front_pointer[deq_conn_in]];
            next_link[queue_front_pointer[deq_conn_in]] <= free_stack_top_pointer;
            free_stack_top_pointer <= queue_front_pointer[deq_conn_in];
            if (queue_front_pointer[deq_conn_in] == queue_back_pointer[deq_conn_in]) begin
              conn_active[deq_conn_in] <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ********************************************************
  // occupancy counters
  // ********************************************************
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      occ_all  <= '0;
      occ_clp1 <= '0;
    end else if (admit) begin
      occ_all <= occ_all + OCC_W'(1);
      if (cell_clp_in) begin
        occ_clp1 <= occ_clp1 + OCC_W'(1);
      end
    end else if (deq_take) begin
      occ_all <= occ_all - OCC_W'(1);
      if (deq_clp_cell) begin
        occ_clp1 <= occ_clp1 - OCC_W'(1);
      end
    end
  end

  // ********************************************************
  // outputs: dequeue, schedule, alarm
  // ********************************************************
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      deq_valid_out <= 1'b0;
      deq_data_out  <= '0;
      deq_clp_out   <= 1'b0;
      deq_mark_out  <= 1'b0;
    end else begin
      deq_valid_out <= deq_take;
      if (deq_take) begin
        {deq_clp_out, deq_mark_out, deq_data_out} <= cell_mem[queue_front_pointer[deq_conn_in]];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sched_valid_out <= 1'b0;
      sched_conn_out  <= '0;
      sched_class_out <= '0;
    end else begin
      sched_valid_out <= admit && !conn_active[cell_conn_in];
      if (admit) begin
        sched_conn_out  <= cell_conn_in;
        sched_class_out <= cfg_class[cell_conn_in];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      fabric_backpressure_alarm_out <= 1'b0;
    end else begin
      fabric_backpressure_alarm_out <= over_thr(occ_all, thr_alarm);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      discard_cnt <= '0;
    end else if (cell_take && !cell_dropped_in && !admit) begin
      discard_cnt <= discard_cnt + 32'h0000_0001;
    end
  end

  // ********************************************************
  // register bus slave
  // ********************************************************
  logic bus_req;
  logic bus_wr;
  assign bus_req             = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = bus_req && !bus_ack;
  assign bus_wr              = avs_write_in && bus_ack;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req && !bus_ack;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      thr_clp1   <= cell_admission_pkg::RST_THR_CLP1;
      thr_all    <= cell_admission_pkg::RST_THR_ALL;
      thr_epd    <= cell_admission_pkg::RST_THR_EPD;
      thr_mark   <= cell_admission_pkg::RST_THR_MARK;
      thr_alarm  <= cell_admission_pkg::RST_THR_ALARM;
      conn_sel   <= '0;
      cfg_police <= '0;
      for (int i = 0; i < CONNS; i++) begin
        cfg_class[i] <= '0;
      end
    end else if (bus_wr) begin
      if (avs_address_in == cell_admission_pkg::OFS_THR_CLP1) begin
        thr_clp1 <= merge16(thr_clp1, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == cell_admission_pkg::OFS_THR_ALL) begin
        thr_all <= merge16(thr_all, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == cell_admission_pkg::OFS_THR_EPD) begin
        thr_epd <= merge16(thr_epd, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == cell_admission_pkg::OFS_THR_MARK) begin
        thr_mark <= merge16(thr_mark, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == cell_admission_pkg::OFS_THR_ALARM) begin
        thr_alarm <= merge16(thr_alarm, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == cell_admission_pkg::OFS_CONN_SEL && avs_byteenable_in[0]) begin
        conn_sel <= avs_writedata_in[CONN_AW-1:0];
      end else if (avs_address_in == cell_admission_pkg::OFS_CONN_CFG && avs_byteenable_in[0]) begin
        cfg_police[conn_sel] <= avs_writedata_in[cell_admission_pkg::CFG_POLICE_BIT];
        cfg_class[conn_sel]  <= avs_writedata_in[cell_admission_pkg::CFG_CLASS_LSB +: cell_admission_pkg::CLASS_W];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      avs_readdata_out <= cell_admission_pkg::ZERO_WORD;
    end else if (avs_read_in && !bus_ack) begin
      if (avs_address_in == cell_admission_pkg::OFS_THR_CLP1) begin
        avs_readdata_out <= {16'h0000, thr_clp1};
      end else if (avs_address_in == cell_admission_pkg::OFS_THR_ALL) begin
        avs_readdata_out <= {16'h0000, thr_all};
      end else if (avs_address_in == cell_admission_pkg::OFS_THR_EPD) begin
        avs_readdata_out <= {16'h0000, thr_epd};
      end else if (avs_address_in == cell_admission_pkg::OFS_THR_MARK) begin
        avs_readdata_out <= {16'h0000, thr_mark};
      end else if (avs_address_in == cell_admission_pkg::OFS_THR_ALARM) begin
        avs_readdata_out <= {16'h0000, thr_alarm};
      end else if (avs_address_in == cell_admission_pkg::OFS_CONN_SEL) begin
        avs_readdata_out <= {{(32-CONN_AW){1'b0}}, conn_sel};
      end else if (avs_address_in == cell_admission_pkg::OFS_CONN_CFG) begin
        avs_readdata_out <= {29'h0000_0000, cfg_class[conn_sel], cfg_police[conn_sel]};
      end else if (avs_address_in == cell_admission_pkg::OFS_STATUS) begin
        avs_readdata_out <= {14'h0000, state == cell_admission_pkg::ST_RUN, fabric_backpressure_alarm_out,
                             {(16-OCC_W){1'b0}}, occ_all};
      end else if (avs_address_in == cell_admission_pkg::OFS_DISCARD_CNT) begin
        avs_readdata_out <= discard_cnt;
      end else begin
        avs_readdata_out <= cell_admission_pkg::ZERO_WORD;
      end
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  sequence s_police_reject;
    cell_take && !cell_dropped_in && police_drop;
  endsequence

  sequence s_new_session;
    admit && !conn_active[cell_conn_in];
  endsequence

  a_police_drop_cell: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    s_police_reject |=> $stable(occ_all) || deq_take == 1'b0 && occ_all != $past(occ_all) + OCC_W'(1))
    else $error("policed cell was admitted");

  a_pass_admits_cell: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    admit && !deq_take |=> occ_all == $past(occ_all) + OCC_W'(1))
    else $error("admitted cell not counted");

  a_full_refuses: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    free_empty |-> !admit)
    else $error("cell admitted with no free cell");

  a_session_sched: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    s_new_session |=> sched_valid_out && sched_conn_out == $past(cell_conn_in) ##1 !sched_valid_out || $past(admit))
    else $error("new session not scheduled");

  a_session_active: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    s_new_session ##1 (!deq_take)[*2] |-> conn_active[$past(cell_conn_in, 2)])
    else $error("connection not active after admission");

  a_alarm_follows: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    over_thr(occ_all, thr_alarm) && $stable(thr_alarm) ##1 $stable(occ_all) |-> fabric_backpressure_alarm_out)
    else $error("alarm not raised above threshold");

  a_ppd_holds: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    cell_take && ppd_active[cell_conn_in] |-> !admit)
    else $error("cell admitted during partial packet discard");

  a_deq_returns: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    deq_take |=> deq_valid_out && free_stack_top_pointer == $past(queue_front_pointer[deq_conn_in]))
    else $error("dequeued cell not returned to free stack");

  a_bus_one_wait: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(bus_req) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("bus answer not after one wait cycle");

  a_clp1_limit: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    cell_take && cell_clp_in && over_thr(occ_clp1, thr_clp1) |-> !admit)
    else $error("low priority cell admitted above threshold");
endmodule

// File: testbench/cell_admission_vc_queue_manager_tb.sv
`timescale 1ns/1ps
module cell_admission_vc_queue_manager_tb;
  logic        clk_sys_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_be = 4'hF;
  logic        deq_req = 1'b0;
  logic [3:0]  deq_conn = 4'h0;
  logic [31:0] rdata, rd;
  logic        waitreq, ready, cvalid, dvalid, dclp, dmark, svalid, alarm;
  logic [3:0]  cconn, sconn, sconn_last;
  logic [31:0] cdata, ddata;
  logic [3:0]  cflags;
  logic [1:0]  sclass, sclass_last;
  int          err_total = 0;
  int          checks = 0;
  int          sched_seen = 0;
  logic [7:0]  rst_ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24};
  logic [31:0] rst_val [9] = '{32'h0000_0030, 32'h0000_0040, 32'h0000_0038, 32'h0000_0020,
                               32'h0000_0030, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  localparam logic [31:0] D3 = 32'h0000_00A0;
  localparam logic [31:0] D5 = 32'h0000_00B0;

  always #10 clk_sys_in = ~clk_sys_in;

  cell_admission_vc_queue_manager cell_admission_vc_queue_manager_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .cell_valid_in(cvalid), .cell_ready_out(ready), .cell_conn_in(cconn), .cell_data_in(cdata),
    .cell_clp_in(cflags[3]), .cell_eop_in(cflags[2]), .cell_conform_in(cflags[1]), .cell_dropped_in(cflags[0]),
    .deq_req_in(deq_req), .deq_conn_in(deq_conn), .deq_valid_out(dvalid), .deq_data_out(ddata),
    .deq_clp_out(dclp), .deq_mark_out(dmark), .sched_valid_out(svalid), .sched_conn_out(sconn),
    .sched_class_out(sclass), .fabric_backpressure_alarm_out(alarm));

  cell_source cell_source_inst (
    .clk_sys_in(clk_sys_in), .cell_ready_in(ready), .cell_valid_out(cvalid),
    .cell_conn_out(cconn), .cell_data_out(cdata), .cell_flags_out(cflags));

  // ********************************************************
  // monitors and helpers
  // ********************************************************
  always @(posedge clk_sys_in) begin
    if (svalid === 1'b1) begin
      sched_seen++;
      sconn_last <= sconn;
      sclass_last <= sclass;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (waitreq !== 1'b0) err_total++;
    rd = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk($sformatf("register %h", a), exp, rd);
  endtask

  task automatic status(input logic [6:0] occ, input logic al);
    rdchk(cell_admission_pkg::OFS_STATUS, {14'h0000, 1'b1, al, 9'h000, occ});
    chk("alarm pin", {31'h0000_0000, al}, {31'h0000_0000, alarm});
  endtask

  task automatic deq(input logic [3:0] c, input logic v, input logic [31:0] d, input logic [1:0] m);
    @(posedge clk_sys_in);
    deq_req <= 1'b1;
    deq_conn <= c;
    @(posedge clk_sys_in);
    deq_req <= 1'b0;
    deq_conn <= ~c;
    #1;
    chk("deq valid", {31'h0000_0000, v}, {31'h0000_0000, dvalid});
    if (v) begin
      chk("deq data", d, ddata);
      chk("deq clp mark", {30'h0000_0000, m}, {30'h0000_0000, dclp, dmark});
    end
  endtask

  task automatic test_done;
    err_total += cell_source_inst.late;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ********************************************************
  // tests
  // ********************************************************
  initial begin
    #400000;
    err_total++;
    test_done;
  end

  initial begin
    int n;
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 9; i++) rdchk(rst_ofs[i], rst_val[i]);
    n = 0;
    do begin
      bus(1'b0, cell_admission_pkg::OFS_STATUS, 32'h0000_0000);
      n++;
    end while (rd[cell_admission_pkg::STAT_READY_BIT] !== 1'b1 && n < 100);
    status(7'h00, 1'b0);
    bus(1'b1, cell_admission_pkg::OFS_THR_MARK, 32'h0000_0002);
    bus(1'b1, cell_admission_pkg::OFS_THR_ALARM, 32'h0000_0003);
    bus(1'b1, cell_admission_pkg::OFS_THR_ALL, 32'h0000_0004);
    bus(1'b1, cell_admission_pkg::OFS_CONN_SEL, 32'h0000_0003);
    bus(1'b1, cell_admission_pkg::OFS_CONN_CFG, 32'h0000_0004);
    bus(1'b1, 8'h24, 32'hFFFF_FFFF);
    rdchk(8'h24, 32'h0000_0000);
    for (int i = 0; i < 4; i++) cell_source_inst.send(4'h3, D3 + i, 4'b0110);
    chk("sched count", 32'h0000_0001, sched_seen);
    chk("sched conn", 32'h0000_0003, {28'h000_0000, sconn_last});
    chk("sched class", 32'h0000_0002, {30'h0000_0000, sclass_last});
    status(7'h04, 1'b1);
    // first non-final cell of a packet over the total threshold starts partial discard
    cell_source_inst.send(4'h3, D3 + 15, 4'b0010);
    rdchk(cell_admission_pkg::OFS_DISCARD_CNT, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      deq(4'h3, 1'b1, D3 + i, {1'b0, i >= 2});
      if (i == 0) cell_source_inst.send(4'h3, D3 + 14, 4'b0110);
    end
    rdchk(cell_admission_pkg::OFS_DISCARD_CNT, 32'h0000_0002);
    deq(4'h3, 1'b0, 32'h0000_0000, 2'b00);
    status(7'h00, 1'b0);
    bus(1'b1, cell_admission_pkg::OFS_CONN_SEL, 32'h0000_0005);
    bus(1'b1, cell_admission_pkg::OFS_CONN_CFG, 32'h0000_0005);
    rdchk(cell_admission_pkg::OFS_CONN_CFG, 32'h0000_0005);
    cell_source_inst.send(4'h5, D5, 4'b0100);
    cell_source_inst.send(4'h5, D5 + 1, 4'b0101);
    cell_source_inst.send(4'h5, D5 + 2, 4'b0110);
    repeat (2) @(posedge clk_sys_in);
    chk("sched count", 32'h0000_0002, sched_seen);
    chk("sched conn", 32'h0000_0005, {28'h000_0000, sconn_last});
    bus(1'b1, cell_admission_pkg::OFS_THR_CLP1, 32'h0000_0000);
    cell_source_inst.send(4'h5, D5 + 3, 4'b1110);
    rdchk(cell_admission_pkg::OFS_DISCARD_CNT, 32'h0000_0004);
    status(7'h01, 1'b0);
    deq(4'h5, 1'b1, D5 + 2, 2'b00);
    status(7'h00, 1'b0);
    // fill every cell location, one more arrival finds the free stack empty
    bus(1'b1, cell_admission_pkg::OFS_THR_ALL, 32'h0000_FFFF);
    bus(1'b1, cell_admission_pkg::OFS_THR_CLP1, 32'h0000_FFFF);
    bus(1'b1, cell_admission_pkg::OFS_THR_EPD, 32'h0000_FFFF);
    avs_be <= 4'h1;
    bus(1'b1, cell_admission_pkg::OFS_THR_EPD, 32'h0000_1234);
    avs_be <= 4'hF;
    rdchk(cell_admission_pkg::OFS_THR_EPD, 32'h0000_FF34);
    for (int i = 0; i < 65; i++) cell_source_inst.send(4'h7, 32'(i), {i[0], 3'b110});
    rdchk(cell_admission_pkg::OFS_DISCARD_CNT, 32'h0000_0005);
    status(7'h40, 1'b1);
    chk("sched count", 32'h0000_0003, sched_seen);
    for (int i = 0; i < 64; i++) deq(4'h7, 1'b1, 32'(i), {i[0], i >= 2});
    deq(4'h7, 1'b0, 32'h0000_0000, 2'b00);
    // a packet begun below the early discard level completes, a new one is refused
    bus(1'b1, cell_admission_pkg::OFS_THR_EPD, 32'h0000_0001);
    cell_source_inst.send(4'h6, D5 + 4, 4'b0010);
    cell_source_inst.send(4'h7, D5 + 5, 4'b0010);
    cell_source_inst.send(4'h7, D5 + 6, 4'b0110);
    cell_source_inst.send(4'h6, D5 + 7, 4'b0110);
    rdchk(cell_admission_pkg::OFS_DISCARD_CNT, 32'h0000_0007);
    deq(4'h6, 1'b1, D5 + 4, 2'b00);
    deq(4'h6, 1'b1, D5 + 7, 2'b00);
    deq(4'h7, 1'b0, 32'h0000_0000, 2'b00);
    test_done;
  end
endmodule

// File: testbench/cell_source.sv
`timescale 1ns/1ps
module cell_source #(
  parameter int CONN_AW = 4,
  parameter int DATA_W  = 32
) (
  // clock and handshake
  input  wire logic               clk_sys_in,
  input  wire logic               cell_ready_in,
  // cell fields
  output logic                    cell_valid_out,
  output logic      [CONN_AW-1:0] cell_conn_out,
  output logic      [DATA_W-1:0]  cell_data_out,
  output logic      [3:0]         cell_flags_out
);
  // ********************************************************
  // upstream look-up stage, one cell at a time
  // ********************************************************
  // flags are clp, eop, conform, dropped
  int late = 0;
  initial begin
    cell_valid_out = 1'b0;
    cell_conn_out = '0;
    cell_data_out = '0;
    cell_flags_out = 4'h0;
  end
  task automatic send(input logic [CONN_AW-1:0] c, input logic [DATA_W-1:0] d, input logic [3:0] f);
    int n;
    @(posedge clk_sys_in);
    cell_valid_out <= 1'b1;
    cell_conn_out <= c;
    cell_data_out <= d;
    cell_flags_out <= f;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (cell_ready_in !== 1'b1 && n < 200);
    if (cell_ready_in !== 1'b1) late++;
    // released fields show the inverse so stale values are never trusted
    cell_valid_out <= 1'b0;
    cell_conn_out <= ~c;
    cell_data_out <= ~d;
    cell_flags_out <= ~f;
  endtask
endmodule
